//--- rtl/nand_array_busy_timing.sv
// Array busy-timing sequencer: holds the die busy for each array operation.
// Assumes requests come from command decode logic on the same clock.
// Busy lengths are whole mclk cycles; erase and program are parameters.
// One partial program counter per die, cleared by erase or sys_rst.
`timescale 1ns/10ps
module nand_array_busy_timing
  import nand_busy_pkg::*;
#(
  parameter int unsigned ERASE_CYC = ERASE_CYC_DEF,
  parameter int unsigned PROGRAM_CYC = PROGRAM_CYC_DEF
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input nand_busy_pkg::op_req_t req,
  output logic req_ready,
  output logic req_refused,
  output logic op_done,
  output logic data_ready,
  output nand_busy_pkg::busy_status_t status,
  output logic [nand_busy_pkg::PP_W-1:0] program_count
);
  import nand_busy_pkg::*;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_busy = 2'b01,
    st_finish = 2'b11
  } state_t;

  state_t state;
  state_t next_state;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  op_t cur_op;
  op_t next_cur_op;
  logic sync_mode;
  logic next_sync_mode;
  logic switching;
  logic next_switching;
  logic fault;
  logic next_fault;
  logic done;
  logic next_done;
  logic rd_ready;
  logic next_rd_ready;
  logic [PP_W-1:0] pcount;
  logic [PP_W-1:0] next_pcount;
  logic refused;
  logic next_refused;
  logic cur_prot;
  logic next_cur_prot;

  // Busy length for an operation
  function automatic logic [CNT_W-1:0] busy_cycles(input op_t op,
                                                  input logic prot,
                                                  input logic sw);
    logic [CNT_W-1:0] c;
    c = CNT_W'(1);
    unique case (op)
      op_page_read: c = CNT_W'(PAGE_READ_CYC);
      op_cache_read: c = CNT_W'(CACHE_READ_CYC);
      op_page_program: c = CNT_W'(PROGRAM_CYC);
      op_block_erase: c = CNT_W'(ERASE_CYC);
      op_feature_get: c = CNT_W'(FEATURE_CYC);
      op_feature_set_sync: begin
        c = sw ? CNT_W'(ITC_CYC) : CNT_W'(FEATURE_CYC);
      end
      op_reset: c = sw ? CNT_W'(ITC_CYC) : CNT_W'(RESET_CYC);
      op_otp_program: begin
        c = prot ? CNT_W'(OTP_PROT_CYC) : CNT_W'(PROGRAM_CYC);
      end
    endcase
    return c;
  endfunction : busy_cycles

  function automatic logic mode_change(input op_req_t r, input logic sm);
    return (r.op == op_feature_set_sync && r.to_sync && !sm) ||
           (r.op == op_reset && sm);
  endfunction : mode_change

  // Partial program count already at the limit for this page kind
  function automatic logic over_limit(input op_req_t r,
                                      input logic [PP_W-1:0] pc);
    logic hit;
    hit = 1'b0;
    if (r.op == op_page_program) begin
      hit = (pc >= PP_W'(PARTIAL_PROGRAM_LIMIT));
    end
    if (r.op == op_otp_program && !r.otp_protected) begin
      hit = (pc >= PP_W'(PARTIAL_PROGRAM_LIMIT_OTP));
    end
    return hit;
  endfunction : over_limit

  // Count sticks at all ones so an overrun never wraps back to legal
  function automatic logic [PP_W-1:0] sat_inc(input logic [PP_W-1:0] v);
    return (&v) ? v : v + PP_W'(1);
  endfunction : sat_inc

  assign req_ready = (state == st_idle);

  // Next state, counts and flags
  always_comb begin
    logic sw_req;
    sw_req = mode_change(req, sync_mode);
    next_state = state;
    next_count = count;
    next_cur_op = cur_op;
    next_cur_prot = cur_prot;
    next_sync_mode = sync_mode;
    next_switching = switching;
    next_fault = fault;
    next_done = 1'b0;
    next_rd_ready = rd_ready;
    next_pcount = pcount;
    next_refused = 1'b0;
    unique case (state)
      st_idle: begin
        if (req.valid) begin
          next_state = st_busy;
          next_cur_op = req.op;
          next_cur_prot = req.otp_protected;
          next_rd_ready = 1'b0;
          next_switching = sw_req;
          next_count = busy_cycles(req.op, req.otp_protected, sw_req);
          if (over_limit(req, pcount)) begin
            next_fault = 1'b1;
          end
        end
      end
      st_busy: begin
        if (req.valid) begin
          next_refused = 1'b1;
        end
        if (count <= CNT_W'(1)) begin
          next_state = st_finish;
        end else begin
          next_count = count - CNT_W'(1);
        end
      end
      st_finish: begin
        next_state = st_idle;
        next_done = 1'b1;
        if (req.valid) begin
          next_refused = 1'b1;
        end
        if (switching) begin
          next_sync_mode = (cur_op == op_feature_set_sync);
        end
        next_switching = 1'b0;
        unique case (cur_op)
          op_page_read, op_cache_read: next_rd_ready = 1'b1;
          op_block_erase: next_pcount = '0;
          op_page_program: next_pcount = sat_inc(pcount);
          op_otp_program: begin
            if (!cur_prot) begin
              next_pcount = sat_inc(pcount);
            end
          end
          default: next_pcount = pcount;
        endcase
      end
      default: next_state = st_idle;
    endcase
  end

  // State registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= st_idle;
      count <= '0;
      cur_op <= op_page_read;
      sync_mode <= 1'b0;
      switching <= 1'b0;
      fault <= 1'b0;
      done <= 1'b0;
      rd_ready <= 1'b0;
      pcount <= '0;
      refused <= 1'b0;
      cur_prot <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      cur_op <= next_cur_op;
      sync_mode <= next_sync_mode;
      switching <= next_switching;
      fault <= next_fault;
      done <= next_done;
      rd_ready <= next_rd_ready;
      pcount <= next_pcount;
      refused <= next_refused;
      cur_prot <= next_cur_prot;
    end
  end

  // Port view of the state
  assign op_done = done;
  assign data_ready = rd_ready;
  assign req_refused = refused;
  assign program_count = pcount;
  always_comb begin
    status = '0;
    status.ready = (state == st_idle);
    status.sync_mode = sync_mode;
    status.interface_switching = switching;
    status.timeout_fault = fault;
  end

endmodule : nand_array_busy_timing

//--- rtl/nand_busy_pkg.sv
// Package for the array busy-timing sequencer: operation codes, busy
// times in their printed units and derived cycle counts at 250 MHz.
// Assumes a single 250 MHz clock domain.
package nand_busy_pkg;

  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned NS_PER_US = 1000;
  localparam int unsigned CLK_PERIOD_NS = 4;

  // Busy times in microseconds, maximum except the typical erase and program times
  localparam int unsigned ERASE_BUSY_TIME_US = 10000;
  localparam int unsigned ERASE_BUSY_TYP_US = 3000;
  localparam int unsigned CACHE_READ_BUSY_TIME_US = 50;
  localparam int unsigned FEATURE_ACCESS_BUSY_TIME_US = 1;
  localparam int unsigned INTERFACE_SWITCH_BUSY_TIME_US = 1;
  localparam int unsigned PROTECTED_OTP_PROGRAM_BUSY_TIME_US = 30;
  localparam int unsigned PAGE_PROGRAM_BUSY_TIME_US = 2200;
  localparam int unsigned PAGE_PROGRAM_TYP_US = 900;
  localparam int unsigned PAGE_READ_BUSY_TIME_US = 50;
  localparam int unsigned RESET_IDLE_BUSY_TIME_US = 5;

  // Busy times to whole cycles; erase and program defaults use the typical times
  localparam int unsigned CACHE_READ_CYC = CACHE_READ_BUSY_TIME_US * CLK_MHZ;
  localparam int unsigned FEATURE_CYC = FEATURE_ACCESS_BUSY_TIME_US * CLK_MHZ;
  localparam int unsigned ITC_CYC = INTERFACE_SWITCH_BUSY_TIME_US * CLK_MHZ;
  localparam int unsigned OTP_PROT_CYC =
    PROTECTED_OTP_PROGRAM_BUSY_TIME_US * CLK_MHZ;
  localparam int unsigned PAGE_READ_CYC = PAGE_READ_BUSY_TIME_US * CLK_MHZ;
  localparam int unsigned RESET_CYC = RESET_IDLE_BUSY_TIME_US * CLK_MHZ;
  localparam int unsigned ERASE_CYC_DEF = ERASE_BUSY_TYP_US * CLK_MHZ;
  localparam int unsigned PROGRAM_CYC_DEF = PAGE_PROGRAM_TYP_US * CLK_MHZ;
  localparam int unsigned ERASE_CYC_MAX = ERASE_BUSY_TIME_US * CLK_MHZ;
  localparam int unsigned PROGRAM_CYC_MAX =
    PAGE_PROGRAM_BUSY_TIME_US * CLK_MHZ;

  localparam int unsigned CNT_W = 22;

  // Partial program limits
  localparam int unsigned PARTIAL_PROGRAM_LIMIT = 1;
  localparam int unsigned PARTIAL_PROGRAM_LIMIT_OTP = 8;
  localparam int unsigned PP_W = 4;

  typedef enum logic [2:0] {
    op_page_read = 3'h0,
    op_cache_read = 3'h1,
    op_page_program = 3'h2,
    op_block_erase = 3'h3,
    op_feature_get = 3'h4,
    op_feature_set_sync = 3'h5,
    op_reset = 3'h6,
    op_otp_program = 3'h7
  } op_t;

  typedef struct packed {
    logic valid;
    op_t op;
    logic otp_protected;
    logic to_sync;
  } op_req_t;

  typedef struct packed {
    logic ready;
    logic sync_mode;
    logic interface_switching;
    logic timeout_fault;
  } busy_status_t;

endpackage : nand_busy_pkg

//--- verif/nand_busy_chk.sv
// Checker: busy cycle counts at the sequencer ports.
// Assumes one clock and a synchronous reset.
`timescale 1ns/10ps
module nand_busy_chk #(
  parameter int unsigned ERASE_CYC = 20,
  parameter int unsigned PROGRAM_CYC = 20
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input nand_busy_pkg::op_req_t req,
  input wire logic req_ready,
  input wire logic op_done,
  input wire logic data_ready,
  input nand_busy_pkg::busy_status_t status
);
  import nand_busy_pkg::*;
  op_req_t r, next_r;
  logic [CNT_W-1:0] n, next_n;
  always_comb begin
    next_r = (req.valid && req_ready) ? req : r;
    next_n = (req.valid && req_ready) ? '0 : n + CNT_W'(!req_ready);
  end
  always_ff @(posedge mclk) begin
    r <= next_r;
    n <= next_n;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_read_time: assert property (
    op_done && r.op == op_page_read |->
    n == PAGE_READ_CYC + 1 && data_ready) else $error("read busy");
  a_cache_time: assert property (
    op_done && r.op == op_cache_read |->
    n == CACHE_READ_CYC + 1 && data_ready) else $error("cache busy");
  a_feat_time: assert property (
    op_done && r.op == op_feature_get |->
    n == FEATURE_CYC + 1) else $error("feature busy");
  a_switch_time: assert property (
    op_done && $past(status.interface_switching) |->
    n == ITC_CYC + 1) else $error("switch busy");
  a_reset_time: assert property (
    op_done && r.op == op_reset && !$past(status.interface_switching) |->
    n == RESET_CYC + 1) else $error("reset busy");
  a_otp_time: assert property (
    op_done && r.op == op_otp_program && r.otp_protected |->
    n == OTP_PROT_CYC + 1) else $error("otp busy");
  a_prog_time: assert property (
    op_done && r.op == op_page_program |->
    n == PROGRAM_CYC + 1) else $error("program busy");
  a_erase_time: assert property (
    op_done && r.op == op_block_erase |->
    n == ERASE_CYC + 1) else $error("erase busy");
endmodule : nand_busy_chk
bind nand_array_busy_timing nand_busy_chk #(.ERASE_CYC(ERASE_CYC),
  .PROGRAM_CYC(PROGRAM_CYC)) nand_busy_chk_inst (.mclk(mclk),
  .sys_rst(sys_rst), .req(req), .req_ready(req_ready), .op_done(op_done),
  .data_ready(data_ready), .status(status));

//--- verif/nand_host_model.sv
// Host model: gates requests and watches busy time.
// Assumes the bench holds send until the take edge.
`timescale 1ns/10ps
module nand_host_model #(parameter int unsigned LIMIT = 20) (
  input wire logic mclk,
  input wire logic send,
  input nand_busy_pkg::op_req_t cmd,
  input wire logic req_ready,
  input nand_busy_pkg::busy_status_t status,
  output nand_busy_pkg::op_req_t req,
  output logic fault
);
  import nand_busy_pkg::*;
  int w = 0;
  assign req = (send && !status.interface_switching) ? cmd : '0;
  always @(posedge mclk) w <= req_ready ? 0 : w + 1;
  assign fault = w > LIMIT;
endmodule : nand_host_model

//--- verif/nand_array_busy_timing_tb.sv
// Bench: runs each array operation, checks busy cycles and flags.
// Assumes host model and checker are compiled before it.
`timescale 1ns/10ps
module nand_array_busy_timing_tb;
  import nand_busy_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic send = 1'b0;
  logic req_ready, req_refused, op_done, data_ready, fault;
  op_req_t cmd = '0;
  op_req_t req;
  busy_status_t status;
  logic [PP_W-1:0] program_count;
  int bad_count = 0, n_tests = 0, cyc = 0, sm = 0, prg = 0, flt = 0;
  always #2 mclk = ~mclk;
  nand_array_busy_timing #(.ERASE_CYC(30), .PROGRAM_CYC(20))
    nand_array_busy_timing_inst (.mclk(mclk), .sys_rst(sys_rst), .req(req),
    .req_ready(req_ready), .req_refused(req_refused), .op_done(op_done),
    .data_ready(data_ready), .status(status), .program_count(program_count));
  nand_host_model #(.LIMIT(PAGE_READ_CYC + 2)) nand_host_model_inst (
    .mclk(mclk), .send(send), .cmd(cmd), .req_ready(req_ready),
    .status(status), .req(req), .fault(fault));
  task automatic wrap_up();
    $display("%0d mismatches in %0d checks", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) bad_count++;
    if (got !== exp) $display("MISMATCH %0t got %b", $time, got);
  endtask : chk
  task automatic run(input op_t o, input logic p, input logic ts, input int e,
                     input logic sw);
    int c;
    @(negedge mclk);
    cmd = '{1'b1, o, p, ts};
    send = 1'b1;
    @(negedge mclk);
    send = 1'b0;
    for (c = 0; op_done !== 1'b1 && c < e + 9; c++) begin
      @(negedge mclk);
      send = (c == 4);
      if (c == 5) chk(req_refused, !sw);
    end
    if (sw) sm = !sm;
    if ((o == op_page_program && prg >= PARTIAL_PROGRAM_LIMIT) ||
        (o == op_otp_program && !p && prg >= PARTIAL_PROGRAM_LIMIT_OTP))
      flt = 1;
    if (o == op_page_program || (o == op_otp_program && !p)) prg++;
    if (o == op_block_erase) prg = 0;
    chk(c == e + 1, 1'b1);
    chk(status.timeout_fault, flt != 0);
    chk(status.sync_mode, sm != 0);
    chk(data_ready, o == op_page_read || o == op_cache_read);
    chk(program_count === PP_W'(prg), 1'b1);
    chk(fault, 1'b0);
  endtask : run
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 50000) bad_count++;
    if (cyc == 50000) wrap_up();
  end
  initial begin
    void'($urandom(394));
    repeat (16) @(negedge mclk);
    sys_rst = 1'b0;
    run(op_page_read, 1'b0, 1'b0, PAGE_READ_CYC, 1'b0);
    run(op_cache_read, 1'b0, 1'b0, CACHE_READ_CYC, 1'b0);
    run(op_feature_get, 1'b0, 1'($urandom), FEATURE_CYC, 1'b0);
    run(op_feature_set_sync, 1'b0, 1'b1, ITC_CYC, 1'b1);
    run(op_reset, 1'b0, 1'($urandom), ITC_CYC, 1'b1);
    run(op_reset, 1'b0, 1'b0, RESET_CYC, 1'b0);
    run(op_otp_program, 1'b1, 1'b0, OTP_PROT_CYC, 1'b0);
    run(op_page_program, 1'b0, 1'b0, 20, 1'b0);
    chk(status.timeout_fault, 1'b0);
    run(op_page_program, 1'b0, 1'b0, 20, 1'b0);
    chk(status.timeout_fault, 1'b1);
    run(op_block_erase, 1'b0, 1'b0, 30, 1'b0);
    @(negedge mclk);
    sys_rst = 1'b1;
    repeat (2) @(negedge mclk);
    sys_rst = 1'b0;
    sm = 0;
    prg = 0;
    flt = 0;
    chk(status.timeout_fault, 1'b0);
    repeat (8) begin
      run(op_otp_program, 1'b0, 1'($urandom), 20, 1'b0);
      chk(status.timeout_fault, 1'b0);
    end
    run(op_otp_program, 1'b0, 1'b0, 20, 1'b0);
    chk(status.timeout_fault, 1'b1);
    wrap_up();
  end
endmodule : nand_array_busy_timing_tb
